// ===== core/fprs_defs.svh
`ifndef FPRS_DEFS_SVH
`define FPRS_DEFS_SVH

// status word field positions
`define FPRS_SW_IE_BIT      0
`define FPRS_SW_EXC_LSB     0
`define FPRS_SW_EXC_MSB     5
`define FPRS_SW_SF_BIT      6
`define FPRS_SW_ES_BIT      7
`define FPRS_SW_C0_BIT      8
`define FPRS_SW_C1_BIT      9
`define FPRS_SW_C2_BIT      10
`define FPRS_SW_TOP_LSB     11
`define FPRS_SW_TOP_MSB     13
`define FPRS_SW_C3_BIT      14
`define FPRS_SW_BUSY_BIT    15

// reset values
`define FPRS_TOP_RESET      3'h0
`define FPRS_EXC_RESET      6'h00
`define FPRS_CC_RESET       4'h0

// widths and counts
`define FPRS_NUM_REGS       8
`define FPRS_REG_W          80
`define FPRS_SW_W           16
`define FPRS_MM_W           64
`define FPRS_EXP_BIAS_EXT   15'h3fff
`define FPRS_EXP_BIAS_DBL   11'h3ff
`define FPRS_EXP_BIAS_SGL   8'h7f

`endif

// ===== core/fprs_pkg.sv
package fprs_pkg;

   typedef enum logic [3:0] {
      FPRS_OP_NONE,
      FPRS_OP_PUSH_LOAD,
      FPRS_OP_POP_STORE,
      FPRS_OP_LOAD_NOPUSH,
      FPRS_OP_STORE_NOPOP,
      FPRS_OP_EXCHANGE,
      FPRS_OP_STORE_STATUS,
      FPRS_OP_SAVE_STATE,
      FPRS_OP_CLEAR_EXC,
      FPRS_OP_REINIT,
      FPRS_OP_LOAD_ENV,
      FPRS_OP_MM_WRITE
   } fprs_op_e;

   typedef enum logic [1:0] {
      FPRS_FMT_EXT,
      FPRS_FMT_DBL,
      FPRS_FMT_SGL,
      FPRS_FMT_INT
   } fprs_fmt_e;

   typedef struct packed {
      fprs_op_e    op;
      fprs_fmt_e   fmt;
      logic [2:0]  idx;
      logic [79:0] data;
      logic [15:0] sw_data;
   } fprs_req_s;

   typedef struct packed {
      logic        valid;
      logic [79:0] data;
      logic [15:0] status;
      logic        status_to_acc;
   } fprs_rsp_s;

endpackage : fprs_pkg

// ===== core/fprs_conv.sv
`timescale 1ns/100ps
`include "fprs_defs.svh"

// widens a memory operand to extended format, or narrows an extended value
module fprs_conv
   import fprs_pkg::*;
(
   // control
   input  wire fprs_fmt_e   fmt_i,
   input  wire logic        narrow_i,
   // data
   input  wire logic [79:0] din_i,
   output logic      [79:0] dout_o
);

   logic [79:0] widen;
   logic [79:0] narrow;

   always_comb
   begin
      widen = din_i;
      unique case (fmt_i)
         FPRS_FMT_EXT: widen = din_i;
         FPRS_FMT_DBL:
         begin
            // zero and denormal inputs keep a zero exponent, integer bit clear
            if (din_i[62:52] == 11'h000)
               widen = {din_i[63], 15'h0000, 1'b0, din_i[51:0], 11'h000};
            else
               widen = {din_i[63],
                        15'(din_i[62:52]) - 15'(`FPRS_EXP_BIAS_DBL) + `FPRS_EXP_BIAS_EXT,
                        1'b1, din_i[51:0], 11'h000};
         end
         FPRS_FMT_SGL:
         begin
            if (din_i[30:23] == 8'h00)
               widen = {din_i[31], 15'h0000, 1'b0, din_i[22:0], 40'h0};
            else
               widen = {din_i[31],
                        15'(din_i[30:23]) - 15'(`FPRS_EXP_BIAS_SGL) + `FPRS_EXP_BIAS_EXT,
                        1'b1, din_i[22:0], 40'h0};
         end
         FPRS_FMT_INT:
         begin
            // raw integer kept in the mantissa, exponent marks an unnormalised value
            widen = {1'b0, `FPRS_EXP_BIAS_EXT + 15'd63, din_i[63:0]};
         end
      endcase
   end

   always_comb
   begin
      narrow = din_i;
      unique case (fmt_i)
         FPRS_FMT_EXT: narrow = din_i;
         // truncation only: rounding belongs to the arithmetic datapath
         FPRS_FMT_DBL: narrow = {16'h0000, din_i[79],
                                 11'(din_i[78:64] - `FPRS_EXP_BIAS_EXT + 15'(`FPRS_EXP_BIAS_DBL)),
                                 din_i[62:11]};
         FPRS_FMT_SGL: narrow = {48'h0, din_i[79],
                                 8'(din_i[78:64] - `FPRS_EXP_BIAS_EXT + 15'(`FPRS_EXP_BIAS_SGL)),
                                 din_i[62:40]};
         FPRS_FMT_INT: narrow = {16'h0000, din_i[63:0]};
      endcase
   end

   assign dout_o = narrow_i ? narrow : widen;

endmodule : fprs_conv

// ===== core/fprs_stack.sv
`timescale 1ns/100ps
`include "fprs_defs.svh"

// Overview of operation
// - eight data registers, each 80 bits, extended-precision format.
// - memory loads are widened to extended precision unless already extended.
// - stores keep extended format or narrow to float or integer format.
// - register index i selects the i-th register counted from the top.
// - pushing load decrements the top pointer, then writes the new top.
// - popping store outputs the top register, then increments the pointer.
// - loads and stores without push or pop leave the pointer alone.
// - push with pointer zero wraps the pointer to seven.
// - push onto an occupied register raises stack overflow indication.
// - registers and pointer are untouched by anything but stack operations and the multimedia write.
// - exchange swaps the top register with another data register.
// - sixteen-bit status word with busy, top, codes, summary, fault, exceptions.
// - top pointer lives in status bits 11 through 13.
// - status stored by status and save ops; status op to accumulator.
// - multimedia registers alias the same storage as the data registers.
// - register and pointer state changes only through this unit's own operation port.
// - stack behaviour does not depend on processor operating mode.
// - error summary bit 7 set when any unmasked exception flag is set.
// - exception bits 0 to 5 stay set until clear, reinit, save or restore.
// - status bit 15 always mirrors the error summary flag.
module fprs_stack
   import fprs_pkg::*;
#(
   parameter int NUM_REGS = `FPRS_NUM_REGS,
   parameter int REG_W    = `FPRS_REG_W
)
(
   // clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   // operation port from the core
   input  wire logic        req_valid_i,
   input  wire fprs_req_s   req_i,
   // exception, busy and condition code inputs from the arithmetic datapath
   input  wire logic [5:0]  exc_event_i,
   input  wire logic [5:0]  exc_mask_i,
   input  wire logic        busy_i,
   input  wire logic        cc_we_i,
   input  wire logic [3:0]  cc_i,
   // answers
   output fprs_rsp_s        rsp_o,
   output logic [15:0]      status_word_o,
   output logic [63:0]      mm_rdata_o,
   output logic             stack_overflow_o
);

   // ****************************************************************
   // storage and state
   // ****************************************************************
   logic [REG_W-1:0] regs_q [NUM_REGS];
   logic [NUM_REGS-1:0] full_q;
   logic [2:0]  top_q;
   logic [5:0]  exc_q;
   logic        sf_q;
   logic [3:0]  cc_q;
   logic        busy_q;
   fprs_rsp_s   rsp_q;
   logic [63:0] mm_rdata_q;
   logic        ovf_q;

   logic        do_op;
   logic [2:0]  top_push;
   logic [2:0]  top_pop;
   logic [2:0]  rel_sel;
   logic [REG_W-1:0] conv_out;
   logic        narrow;
   logic        push_ovf;
   logic        pop_unf;
   logic [5:0]  exc_set;
   logic        es;
   logic [15:0] sw_now;

   assign do_op    = req_valid_i && (req_i.op != FPRS_OP_NONE);
   assign top_push = top_q - 3'h1;
   assign top_pop  = top_q + 3'h1;
   assign rel_sel  = top_q + req_i.idx;
   assign narrow   = (req_i.op == FPRS_OP_POP_STORE) || (req_i.op == FPRS_OP_STORE_NOPOP);

   // full marks stand in for the tag word, enough to see an unsaved overwrite
   assign push_ovf = req_valid_i && (req_i.op == FPRS_OP_PUSH_LOAD) && full_q[top_push];
   assign pop_unf  = req_valid_i && (req_i.op == FPRS_OP_POP_STORE) && !full_q[top_q];

   // stack faults report as invalid operation with the fault flag
   assign exc_set = exc_event_i | {5'h00, push_ovf | pop_unf};

   // ****************************************************************
   // format conversion
   // ****************************************************************
   fprs_conv u_conv (
      .fmt_i    (req_i.fmt),
      .narrow_i (narrow),
      .din_i    (narrow ? regs_q[rel_sel] : req_i.data),
      .dout_o   (conv_out)
   );

   // ****************************************************************
   // data registers
   // ****************************************************************
   // one write process per entry: an exchange is then two plain entry updates
   for (genvar g = 0; g < NUM_REGS; g++)
   begin : g_entry
      logic hit_push;
      logic hit_rel;
      logic hit_top;
      logic hit_abs;

      assign hit_push = (top_push == 3'(g));
      assign hit_rel  = (rel_sel == 3'(g));
      assign hit_top  = (top_q == 3'(g));
      assign hit_abs  = (req_i.idx == 3'(g));

      // only this port writes them, so mode and unrelated state never do
      always_ff @(posedge clock_i or posedge rst_i)
      begin
         if (rst_i)
            regs_q[g] <= '0;
         else if (do_op)
         begin
            unique case (req_i.op)
               FPRS_OP_PUSH_LOAD:
               begin
                  if (hit_push)
                     regs_q[g] <= conv_out;
               end
               FPRS_OP_LOAD_NOPUSH:
               begin
                  if (hit_rel)
                     regs_q[g] <= conv_out;
               end
               // index zero hits both: top wins and the entry keeps its value
               FPRS_OP_EXCHANGE:
               begin
                  if (hit_top)
                     regs_q[g] <= regs_q[rel_sel];
                  else if (hit_rel)
                     regs_q[g] <= regs_q[top_q];
               end
               // multimedia write fills the mantissa and sets exponent all ones
               FPRS_OP_MM_WRITE:
               begin
                  if (hit_abs)
                     regs_q[g] <= {16'hffff, req_i.data[63:0]};
               end
               default: ;
            endcase
         end
      end
   end : g_entry

   // ****************************************************************
   // occupancy marks
   // ****************************************************************
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         full_q <= '0;
      else if (do_op)
      begin
         unique case (req_i.op)
            FPRS_OP_PUSH_LOAD:   full_q[top_push] <= 1'b1;
            FPRS_OP_POP_STORE:   full_q[top_q]    <= 1'b0;
            FPRS_OP_LOAD_NOPUSH: full_q[rel_sel]  <= 1'b1;
            FPRS_OP_EXCHANGE:
            begin
               full_q[top_q]   <= full_q[rel_sel];
               full_q[rel_sel] <= full_q[top_q];
            end
            FPRS_OP_MM_WRITE:    full_q <= '1;
            FPRS_OP_REINIT:      full_q <= '0;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // top pointer
   // ****************************************************************
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
         top_q <= `FPRS_TOP_RESET;
      else if (do_op)
      begin
         unique case (req_i.op)
            FPRS_OP_PUSH_LOAD: top_q <= top_push;
            FPRS_OP_POP_STORE: top_q <= top_pop;
            FPRS_OP_REINIT:    top_q <= `FPRS_TOP_RESET;
            FPRS_OP_LOAD_ENV:  top_q <= req_i.sw_data[`FPRS_SW_TOP_MSB:`FPRS_SW_TOP_LSB];
            FPRS_OP_MM_WRITE:  top_q <= `FPRS_TOP_RESET;
            default: ;
         endcase
      end
   end

   // ****************************************************************
   // exception, fault and condition flags
   // ****************************************************************
   // a new event in the clearing cycle survives the clear
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         exc_q <= `FPRS_EXC_RESET;
         sf_q  <= 1'b0;
      end
      else if (req_valid_i && req_i.op == FPRS_OP_LOAD_ENV)
      begin
         exc_q <= req_i.sw_data[`FPRS_SW_EXC_MSB:`FPRS_SW_EXC_LSB] | exc_set;
         sf_q  <= req_i.sw_data[`FPRS_SW_SF_BIT];
      end
      else if (req_valid_i && (req_i.op == FPRS_OP_CLEAR_EXC || req_i.op == FPRS_OP_REINIT
                               || req_i.op == FPRS_OP_SAVE_STATE))
      begin
         exc_q <= exc_set;
         sf_q  <= push_ovf | pop_unf;
      end
      else
      begin
         exc_q <= exc_q | exc_set;
         sf_q  <= sf_q | push_ovf | pop_unf;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cc_q   <= `FPRS_CC_RESET;
         busy_q <= 1'b0;
      end
      else
      begin
         busy_q <= busy_i;
         if (req_valid_i && req_i.op == FPRS_OP_LOAD_ENV)
            cc_q <= {req_i.sw_data[`FPRS_SW_C3_BIT], req_i.sw_data[`FPRS_SW_C2_BIT],
                     req_i.sw_data[`FPRS_SW_C1_BIT], req_i.sw_data[`FPRS_SW_C0_BIT]};
         else if (req_valid_i && req_i.op == FPRS_OP_REINIT)
            cc_q <= `FPRS_CC_RESET;
         else if (push_ovf | pop_unf)
            cc_q <= {cc_q[3:2], push_ovf, cc_q[0]};             // c1 tells overflow from underflow
         else if (cc_we_i)
            cc_q <= cc_i;
      end
   end

   // ****************************************************************
   // status word
   // ****************************************************************
   assign es = |(exc_q & ~exc_mask_i);

   always_comb
   begin
      sw_now = '0;
      sw_now[`FPRS_SW_EXC_MSB:`FPRS_SW_EXC_LSB] = exc_q;
      sw_now[`FPRS_SW_SF_BIT]                   = sf_q;
      sw_now[`FPRS_SW_ES_BIT]                   = es;
      sw_now[`FPRS_SW_C0_BIT]                   = cc_q[0];
      sw_now[`FPRS_SW_C1_BIT]                   = cc_q[1];
      sw_now[`FPRS_SW_C2_BIT]                   = cc_q[2];
      sw_now[`FPRS_SW_TOP_MSB:`FPRS_SW_TOP_LSB] = top_q;
      sw_now[`FPRS_SW_C3_BIT]                   = cc_q[3];
      // busy mirrors summary for compatibility, the core busy input is kept aside
      sw_now[`FPRS_SW_BUSY_BIT]                 = es;
   end

   // ****************************************************************
   // answers
   // ****************************************************************
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rsp_q         <= '0;
         status_word_o <= '0;
         mm_rdata_q    <= '0;
         ovf_q         <= 1'b0;
      end
      else
      begin
         status_word_o       <= sw_now;
         ovf_q               <= push_ovf;
         rsp_q.valid         <= do_op;
         rsp_q.status_to_acc <= req_valid_i && req_i.op == FPRS_OP_STORE_STATUS;
         rsp_q.status        <= sw_now;
         mm_rdata_q          <= regs_q[req_i.idx][63:0];
         unique case (req_i.op)
            // value leaves before the pointer moves: read uses the old top
            FPRS_OP_POP_STORE:   rsp_q.data <= conv_out;
            FPRS_OP_STORE_NOPOP: rsp_q.data <= conv_out;
            FPRS_OP_STORE_STATUS,
            FPRS_OP_SAVE_STATE:  rsp_q.data <= {64'h0, sw_now};
            default:             rsp_q.data <= '0;
         endcase
      end
   end

   assign rsp_o            = rsp_q;
   assign mm_rdata_o       = mm_rdata_q;
   assign stack_overflow_o = ovf_q;

endmodule : fprs_stack

// ===== verif/fprs_stack_assertions.sv
`timescale 1ns/100ps
// ****
// stack checker
// ****
module fprs_stack_assertions
   import fprs_pkg::*;
(
   input  wire logic        clock_i,
   input  wire logic        rst_i,
   input  wire logic        req_valid_i,
   input  wire fprs_req_s   req_i,
   input  wire logic [5:0]  exc_event_i,
   input  wire logic [5:0]  exc_mask_i,
   input  wire fprs_rsp_s   rsp_o,
   input  wire logic [15:0] status_word_o,
   input  wire logic        stack_overflow_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (rst_i);

   logic [2:0] top;
   assign top = status_word_o[13:11];

   // status lags state, so top checks need an idle cycle before the op
   property p_push;
      req_valid_i && req_i.op == FPRS_OP_PUSH_LOAD && !$past(req_valid_i)
         |-> ##2 top == $past(top, 2) - 3'h1;
   endproperty
   a_push: assert property (p_push) else $error("push did not lower top");
   property p_pop;
      req_valid_i && req_i.op == FPRS_OP_POP_STORE && !$past(req_valid_i)
         |-> ##2 top == $past(top, 2) + 3'h1;
   endproperty
   a_pop: assert property (p_pop) else $error("pop did not raise top");
   property p_keep;
      req_valid_i && !$past(req_valid_i) && req_i.op inside {FPRS_OP_LOAD_NOPUSH,
         FPRS_OP_STORE_NOPOP, FPRS_OP_EXCHANGE, FPRS_OP_STORE_STATUS}
         |-> ##2 top == $past(top, 2);
   endproperty
   a_keep: assert property (p_keep) else $error("top moved on plain op");
   property p_answer;
      req_valid_i && req_i.op != FPRS_OP_NONE |=> rsp_o.valid;
   endproperty
   a_answer: assert property (p_answer) else $error("request not answered");
   property p_mirror;
      status_word_o[15] == status_word_o[7];
   endproperty
   a_mirror: assert property (p_mirror) else $error("bit 15 differs from summary");
   property p_es;
      (|(exc_event_i & ~exc_mask_i) && !req_valid_i) ##1 !req_valid_i
         |=> status_word_o[7];
   endproperty
   a_es: assert property (p_es) else $error("summary not set");
   property p_sticky;
      !$past(req_valid_i) && !req_valid_i |=> ##1
         (status_word_o[5:0] & $past(status_word_o[5:0], 2)) == $past(status_word_o[5:0], 2);
   endproperty
   a_sticky: assert property (p_sticky) else $error("exception flag dropped");
   property p_ovf;
      stack_overflow_o |-> $past(req_valid_i) && $past(req_i.op) == FPRS_OP_PUSH_LOAD;
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow without push");
   property p_acc;
      req_valid_i && req_i.op == FPRS_OP_STORE_STATUS |=> rsp_o.status_to_acc;
   endproperty
   a_acc: assert property (p_acc) else $error("status not sent to accumulator");

   c_wrap: cover property (req_valid_i && req_i.op == FPRS_OP_PUSH_LOAD && top == 3'h0);
   c_ovf: cover property (stack_overflow_o);
   c_xchg: cover property (req_valid_i && req_i.op == FPRS_OP_EXCHANGE);
endmodule : fprs_stack_assertions

bind fprs_stack fprs_stack_assertions u_fprs_stack_assertions (
   .clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
   .exc_event_i(exc_event_i), .exc_mask_i(exc_mask_i), .rsp_o(rsp_o),
   .status_word_o(status_word_o), .stack_overflow_o(stack_overflow_o));

// ===== verif/fprs_core_model.sv
`timescale 1ns/100ps
// ****
// memory and accumulator side of the core
// ****
module fprs_core_model
   import fprs_pkg::*;
(
   input  wire logic      clock_i,
   input  wire logic      rst_i,
   input  wire fprs_rsp_s rsp_i,
   output logic [79:0]    mem_o,
   output logic [15:0]    acc_o
);
   always_ff @(posedge clock_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem_o <= '0;
         acc_o <= '0;
      end
      else if (rsp_i.valid)
      begin
         mem_o <= rsp_i.data;
         if (rsp_i.status_to_acc)
         begin
            acc_o <= rsp_i.data[15:0];
         end
      end
   end
endmodule : fprs_core_model

// ===== verif/fprs_stack_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module fprs_stack_tb_top
   import fprs_pkg::*;
;
   logic        clock_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        req_valid_i = 1'b0;
   fprs_req_s   req_i = '0;
   logic [5:0]  exc_event_i = '0;
   logic [5:0]  exc_mask_i = '0;
   fprs_rsp_s   rsp_o;
   logic [15:0] sw;
   logic [63:0] mm;
   logic        ovf;
   logic [79:0] mem;
   logic [15:0] acc;
   logic [79:0] msk;
   int          fails = 0;
   int          num_checks = 0;
   localparam logic [79:0] ONE = 80'h3fff_8000_0000_0000_0000;
   fprs_fmt_e   fi[5] = '{FPRS_FMT_DBL, FPRS_FMT_SGL, FPRS_FMT_INT, FPRS_FMT_EXT, FPRS_FMT_EXT};
   fprs_fmt_e   fo[5] = '{FPRS_FMT_EXT, FPRS_FMT_EXT, FPRS_FMT_EXT, FPRS_FMT_DBL, FPRS_FMT_SGL};
   logic [79:0] di[5] = '{80'h3ff0_0000_0000_0000, 80'h3f80_0000, 80'h5, ONE, ONE};
   logic [79:0] eo[5] = '{ONE, ONE, 80'h403e_0000_0000_0000_0005,
                          80'h3ff0_0000_0000_0000, 80'h3f80_0000};

   always #50 clock_i = ~clock_i;

   fprs_stack u_fprs_stack (
      .clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
      .exc_event_i(exc_event_i), .exc_mask_i(exc_mask_i), .busy_i(1'b0), .cc_we_i(1'b0),
      .cc_i(4'h0), .rsp_o(rsp_o), .status_word_o(sw), .mm_rdata_o(mm),
      .stack_overflow_o(ovf));
   fprs_core_model u_fprs_core_model (
      .clock_i(clock_i), .rst_i(rst_i), .rsp_i(rsp_o), .mem_o(mem), .acc_o(acc));

   // ****
   // access tasks
   // ****
   task automatic issue(input fprs_op_e op, input fprs_fmt_e f, input logic [2:0] i,
                        input logic [79:0] d);
      req_valid_i = 1'b1;
      req_i = '{op, f, i, d, 16'h0000};
      @(posedge clock_i);
      #1;
   endtask : issue

   // valid stays high between back-to-back issues; only idle drops it
   task automatic idle(input int n);
      req_valid_i = 1'b0;
      repeat (n) @(posedge clock_i);
      #1;
   endtask : idle

   task automatic evt(input logic [5:0] e);
      exc_event_i = e;
      @(posedge clock_i);
      #1;
      exc_event_i = 6'h00;
   endtask : evt

   task automatic results;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
      begin
         $display("Result: passed");
      end
      else
      begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   // ****
   // tests
   // ****
   initial
   begin
      repeat (4) @(posedge clock_i);
      #1;
      rst_i = 1'b0;
      `CHK("reset status", 16'h0000, sw)
      issue(FPRS_OP_PUSH_LOAD, FPRS_FMT_EXT, 3'h0, 80'ha1);
      issue(FPRS_OP_PUSH_LOAD, FPRS_FMT_EXT, 3'h0, 80'hb2);
      issue(FPRS_OP_PUSH_LOAD, FPRS_FMT_EXT, 3'h0, 80'hc3);
      idle(1);
      `CHK("top after pushes", 3'h5, sw[13:11])
      issue(FPRS_OP_EXCHANGE, FPRS_FMT_EXT, 3'h2, 80'h0);
      issue(FPRS_OP_STORE_NOPOP, FPRS_FMT_EXT, 3'h0, 80'h0);
      `CHK("exchanged top", 80'ha1, rsp_o.data)
      idle(1);
      `CHK("top kept", 3'h5, sw[13:11])
      issue(FPRS_OP_POP_STORE, FPRS_FMT_EXT, 3'h0, 80'h0);
      `CHK("pop 1", 80'ha1, rsp_o.data)
      issue(FPRS_OP_POP_STORE, FPRS_FMT_EXT, 3'h0, 80'h0);
      `CHK("pop 2", 80'hb2, rsp_o.data)
      issue(FPRS_OP_POP_STORE, FPRS_FMT_EXT, 3'h0, 80'h0);
      `CHK("pop 3", 80'hc3, rsp_o.data)
      idle(1);
      `CHK("top wrapped up", 3'h0, sw[13:11])
      `CHK("memory copy", 80'hc3, mem)
      issue(FPRS_OP_LOAD_NOPUSH, FPRS_FMT_EXT, 3'h1, 80'h77);
      issue(FPRS_OP_STORE_NOPOP, FPRS_FMT_EXT, 3'h1, 80'h0);
      `CHK("plain load", 80'h77, rsp_o.data)
      req_i.idx = 3'h7;
      idle(1);
      `CHK("alias read", 64'hc3, mm)
      issue(FPRS_OP_MM_WRITE, FPRS_FMT_EXT, 3'h3, 80'h5a5a);
      req_i.idx = 3'h3;
      idle(2);
      `CHK("alias write", 64'h5a5a, mm)
      issue(FPRS_OP_REINIT, FPRS_FMT_EXT, 3'h0, 80'h0);
      for (int k = 0; k < 5; k++)
      begin
         issue(FPRS_OP_PUSH_LOAD, fi[k], 3'h0, di[k]);
         issue(FPRS_OP_POP_STORE, fo[k], 3'h0, 80'h0);
         msk = (fo[k] == FPRS_FMT_SGL) ? 80'hffff_ffff :
               (fo[k] == FPRS_FMT_DBL) ? 80'hffff_ffff_ffff_ffff : '1;
         `CHK("conversion", eo[k], rsp_o.data & msk)
      end
      issue(FPRS_OP_REINIT, FPRS_FMT_EXT, 3'h0, 80'h0);
      for (int k = 0; k < 8; k++)
      begin
         issue(FPRS_OP_PUSH_LOAD, FPRS_FMT_EXT, 3'h0, 80'h10 + k);
      end
      `CHK("no overflow yet", 1'b0, ovf)
      issue(FPRS_OP_PUSH_LOAD, FPRS_FMT_EXT, 3'h0, 80'h99);
      `CHK("overflow pulse", 1'b1, ovf)
      idle(3);
      `CHK("overflow status", 16'hbac1, sw)
      issue(FPRS_OP_STORE_STATUS, FPRS_FMT_EXT, 3'h0, 80'h0);
      idle(1);
      `CHK("accumulator", 16'hbac1, acc)
      issue(FPRS_OP_SAVE_STATE, FPRS_FMT_EXT, 3'h0, 80'h0);
      `CHK("saved status", 16'hbac1, rsp_o.data[15:0])
      `CHK("status field", 16'hbac1, rsp_o.status)
      idle(1);
      `CHK("save clears", 8'h00, {sw[15], sw[7], sw[5:0]})
      exc_mask_i = 6'h3f;
      evt(6'h04);
      idle(1);
      `CHK("masked flag", 8'h04, {sw[15], sw[7], sw[5:0]})
      exc_mask_i = 6'h37;
      evt(6'h08);
      idle(1);
      `CHK("unmasked flag", 8'hcc, {sw[15], sw[7], sw[5:0]})
      issue(FPRS_OP_CLEAR_EXC, FPRS_FMT_EXT, 3'h0, 80'h0);
      idle(2);
      `CHK("cleared", 8'h00, {sw[15], sw[7], sw[5:0]})
      results();
   end

   initial
   begin
      repeat (2000) @(posedge clock_i);
      fails++;
      results();
   end
endmodule : fprs_stack_tb_top
